/* File: src/memory_scan_unit.sv */
// Memory scan unit: register file, debugger handling and checksum scanner.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module memory_scan_unit #(
	parameter int ADDR_W = 16
) (
	input  wire logic              clk,
	input  wire logic              srst,
	// Avalon-MM slave, word index address.
	input  wire logic [1:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// Debugger side, same clock domain.
	input  wire scan_pkg::debug_evt_s dbg_evt,
	input  wire logic              dbg_status_we,
	input  wire logic [1:0]        dbg_status_wdata,
	output logic      [1:0]        dbg_status_copy,
	// Startup scan request and section limits in bytes.
	input  wire logic              startup_scan,
	input  wire logic [1:0]        startup_region,
	input  wire logic [ADDR_W-1:0] flash_end,
	input  wire logic [ADDR_W-1:0] boot_end,
	input  wire logic [ADDR_W-1:0] app_end,
	// Flash word fetch port.
	output logic      [ADDR_W-1:0] flash_addr,
	output logic                   flash_rd,
	input  wire logic [15:0]       flash_rdata,
	output logic                   cpu_stall,
	output logic                   failure_irq
);
	import scan_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	logic              enable_r;
	logic              irq_en_r;
	logic [7:0]        srcmode_r;
	logic              busy_r;
	logic              pass_r;
	logic              pass_force_r;
	logic              irq_r;
	logic              held_r;
	logic              pending_r;
	logic              srst_strobe_r;
	logic              startup_done_r;
	scan_state_e       state_r;
	logic [1:0]        cnt_r;
	logic [ADDR_W-1:0] addr_r;
	logic [15:0]       crc_r;
	logic [15:0]       crc_nxt;
	logic              rd_ack_r;
	logic [ADDR_W-1:0] end_addr;
	logic              wr;
	logic              rd;
	logic              start_req;
	logic              release_evt;
	logic              fail_evt;
	logic              pass_evt;
	logic              last_word;
	logic [7:0]        wdata;

	// Reads take one wait state, so the registered data already stands
	// when the master takes it; writes are taken at once.
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_ack_r <= 1'b0;
		end else begin
			rd_ack_r <= rd && !rd_ack_r;
		end
	end
	assign avs_waitrequest = rd && !rd_ack_r;
	assign wr    = avs_write & avs_byteenable[0] & ~irq_r;
	assign rd    = avs_read;
	assign wdata = avs_writedata[7:0];

	// Internal access, disconnect or a status read lets the unit run again.
	assign release_evt = dbg_evt.int_access | dbg_evt.disconnect
		| dbg_evt.status_read;

	// ************************************************************
	// Self-reset strobe
	// ************************************************************
	// Strobe is delayed one cycle so the clear lands after the write.
	always_ff @(posedge clk) begin
		if (srst) begin
			srst_strobe_r <= 1'b0;
		end else begin
			srst_strobe_r <= wr && avs_address == REG_CONTROL_IDX
				&& wdata[CTL_SRST_BIT]
				&& (!irq_en_r || !busy_r);
		end
	end

	// ************************************************************
	// Control register
	// ************************************************************
	// The CPU and the debugger share this write path.
	assign start_req = wr && avs_address == REG_CONTROL_IDX
		&& wdata[CTL_ENABLE_BIT] && !wdata[CTL_SRST_BIT];

	always_ff @(posedge clk) begin
		if (srst) begin
			enable_r       <= CONTROL_RST[CTL_ENABLE_BIT];
			startup_done_r <= 1'b0;
		end else if (srst_strobe_r) begin
			enable_r <= 1'b0;
		end else if (!startup_done_r) begin
			startup_done_r <= 1'b1;
			enable_r       <= startup_scan;
		end else if (start_req) begin
			enable_r <= 1'b1;
		end
	end

	// Only a system reset can clear the irq enable.
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_en_r <= CONTROL_RST[CTL_IRQEN_BIT];
		end else if (wr && avs_address == REG_CONTROL_IDX && !busy_r
				&& wdata[CTL_IRQEN_BIT]) begin
			irq_en_r <= 1'b1;
		end
	end

	// ************************************************************
	// Source and mode register
	// ************************************************************
	// A startup scan leaves the mode field non-zero for software to fix.
	always_ff @(posedge clk) begin
		if (srst) begin
			srcmode_r <= SRCMODE_RST;
		end else if (srst_strobe_r) begin
			srcmode_r <= SRCMODE_RST;
		end else if (!startup_done_r && startup_scan) begin
			srcmode_r <= {2'h0, ~MODE_PRIORITY, 2'h0, startup_region};
		end else if (wr && avs_address == REG_SRCMODE_IDX && !busy_r) begin
			srcmode_r <= wdata & SRCMODE_MASK;
		end
	end

	// Section end by region; reserved code falls back to whole flash.
	always_comb begin
		case (srcmode_r[SRC_LSB +: 2])
			REGION_BOOT_APP: end_addr = app_end;
			REGION_BOOT:     end_addr = boot_end;
			default:         end_addr = flash_end;
		endcase
	end

	// ************************************************************
	// Debugger hold
	// ************************************************************
	// Any debugger memory access holds the scanner.
	always_ff @(posedge clk) begin
		if (srst || srst_strobe_r) begin
			held_r <= 1'b0;
		end else if (dbg_evt.mem_access) begin
			held_r <= 1'b1;
		end else if (release_evt) begin
			held_r <= 1'b0;
		end
	end

	// A pending scan waits for release; busy-zero from debugger drops it.
	always_ff @(posedge clk) begin
		if (srst || srst_strobe_r) begin
			pending_r <= 1'b0;
		end else if (dbg_status_we && !irq_r) begin
			pending_r <= dbg_status_wdata[ST_BUSY_BIT];
		end else if (dbg_evt.mem_access && busy_r) begin
			pending_r <= 1'b1;
		end else if (start_req && (held_r || dbg_evt.mem_access)) begin
			pending_r <= 1'b1;
		end else if (!held_r && state_r == ST_IDLE && pending_r) begin
			pending_r <= 1'b0;
		end
	end

	// ************************************************************
	// Scan engine
	// ************************************************************
	crc16_word u_crc (
		.crc_in  (crc_r),
		.word_in (flash_rdata),
		.crc_out (crc_nxt)
	);

	assign last_word = addr_r >= end_addr - ADDR_W'(2);
	assign flash_addr = addr_r;
	assign flash_rd   = state_r == ST_FETCH && cnt_r == 2'(FETCH_CYC - 1)
		&& !held_r;
	assign cpu_stall  = busy_r && !held_r
		&& srcmode_r[MODE_LSB +: 2] == MODE_PRIORITY;

	// Words come every third cycle; the last word holds the checksum.
	always_ff @(posedge clk) begin
		if (srst || srst_strobe_r || (dbg_status_we && !irq_r)) begin
			state_r <= ST_IDLE;
			cnt_r   <= 2'h0;
			addr_r  <= '0;
			crc_r   <= CRC_INIT;
		end else if (held_r || dbg_evt.mem_access) begin
			state_r <= ST_IDLE;
			cnt_r   <= 2'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (start_req || pending_r
							|| (!startup_done_r && startup_scan)) begin
						state_r <= ST_WAIT;
						cnt_r   <= 2'h0;
						addr_r  <= '0;
						crc_r   <= CRC_INIT;
					end
				end
				ST_WAIT: begin
					cnt_r <= cnt_r + 2'h1;
					if (cnt_r == 2'(START_DELAY_CYC - 1)) begin
						state_r <= ST_FETCH;
						cnt_r   <= 2'h0;
					end
				end
				ST_FETCH: begin
					cnt_r <= cnt_r + 2'h1;
					if (cnt_r == 2'(FETCH_CYC - 1)) begin
						cnt_r       <= 2'h0;
						crc_r       <= crc_nxt;
						addr_r      <= addr_r + ADDR_W'(2);
						if (last_word) begin
							state_r <= ST_CHECK;
						end
					end
				end
				ST_CHECK: state_r <= ST_IDLE;
				default:  state_r <= ST_IDLE;
			endcase
		end
	end

	// Folding the stored checksum in leaves zero on a match.
	assign pass_evt = state_r == ST_CHECK && crc_r == 16'h0000;
	assign fail_evt = state_r == ST_CHECK && crc_r != 16'h0000;

	// ************************************************************
	// Status register
	// ************************************************************
	// Busy covers the start delay and stays up while held.
	always_ff @(posedge clk) begin
		if (srst || srst_strobe_r) begin
			busy_r <= STATUS_RST[ST_BUSY_BIT];
		end else if (dbg_status_we && !irq_r) begin
			busy_r <= dbg_status_wdata[ST_BUSY_BIT];
		end else if (state_r == ST_CHECK && !held_r) begin
			busy_r <= 1'b0;
		end else if (state_r != ST_IDLE || start_req
				|| (!startup_done_r && startup_scan)) begin
			busy_r <= 1'b1;
		end
	end

	// Pass flag; a hardware failure wins over a debugger write.
	always_ff @(posedge clk) begin
		if (srst || srst_strobe_r) begin
			pass_r       <= STATUS_RST[ST_PASS_BIT];
			pass_force_r <= 1'b0;
		end else if (fail_evt) begin
			pass_r       <= 1'b0;
			pass_force_r <= 1'b0;
		end else if (dbg_status_we && !irq_r) begin
			pass_r       <= dbg_status_wdata[ST_PASS_BIT];
			pass_force_r <= dbg_status_wdata[ST_PASS_BIT];
		end else if (pass_evt) begin
			pass_r <= 1'b1;
		end
	end

	// Failure irq sticks until system reset, never cleared by strobe.
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_r <= 1'b0;
		end else if (irq_en_r && (fail_evt || (dbg_status_we
				&& !dbg_status_wdata[ST_PASS_BIT]))) begin
			irq_r <= 1'b1;
		end
	end
	assign failure_irq = irq_r;

	// Synchronous copy for the debugger.
	always_ff @(posedge clk) begin
		if (srst) begin
			dbg_status_copy <= STATUS_RST[1:0];
		end else begin
			dbg_status_copy <= {pass_r | (pass_force_r & ~busy_r), busy_r};
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	// Unused bits and the unmapped index read as zero.
	always_ff @(posedge clk) begin
		if (srst) begin
			avs_readdata <= 32'h0;
		end else if (rd && !rd_ack_r) begin
			case (avs_address)
				REG_CONTROL_IDX: avs_readdata <= {30'h0, irq_en_r, enable_r};
				REG_SRCMODE_IDX: avs_readdata <= {24'h0, srcmode_r};
				REG_STATUS_IDX:  avs_readdata <= {30'h0,
					pass_r | (pass_force_r & ~busy_r), busy_r};
				default:         avs_readdata <= 32'h0;
			endcase
		end
	end
endmodule

/* File: src/scan_pkg.sv */
// Package with register map, field positions and timing of the memory scan unit.
package scan_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [1:0] REG_CONTROL_IDX  = 2'h0;
	localparam logic [1:0] REG_SRCMODE_IDX  = 2'h1;
	localparam logic [1:0] REG_STATUS_IDX   = 2'h2;
	localparam logic [1:0] REG_DEBUG_IDX    = 2'h3;
	localparam logic [7:0] CONTROL_RST      = 8'h00;
	localparam logic [7:0] SRCMODE_RST      = 8'h00;
	localparam logic [7:0] STATUS_RST       = 8'h02;
	// Field positions.
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_IRQEN_BIT  = 1;
	localparam int CTL_SRST_BIT   = 7;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_PASS_BIT    = 1;
	localparam int SRC_LSB        = 0;
	localparam int MODE_LSB       = 4;
	localparam logic [7:0] SRCMODE_MASK = 8'h33;
	// Region and mode codes.
	localparam logic [1:0] REGION_FLASH    = 2'h0;
	localparam logic [1:0] REGION_BOOT_APP = 2'h1;
	localparam logic [1:0] REGION_BOOT     = 2'h2;
	localparam logic [1:0] MODE_PRIORITY   = 2'h0;
	// ************************************************************
	// Checksum and timing
	// ************************************************************
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam int START_DELAY_CYC = 3;
	localparam int FETCH_CYC       = 3;
	// Debugger event codes on the debug port.
	typedef struct packed {
		logic mem_access;
		logic int_access;
		logic disconnect;
		logic status_read;
	} debug_evt_s;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_FETCH,
		ST_CHECK
	} scan_state_e;
endpackage

/* File: src/crc16_word.sv */
// One 16-bit flash word folded into the running CRC, high byte first.
`timescale 1ns/1ps
module crc16_word (
	input  wire logic [15:0] crc_in,
	input  wire logic [15:0] word_in,
	output logic      [15:0] crc_out
);
	import scan_pkg::*;
	// Bitwise shift register, most significant bit of each byte first.
	always_comb begin
		logic [15:0] c;
		c = crc_in;
		for (int i = 15; i >= 0; i--) begin
			if (c[15] ^ word_in[i]) begin
				c = {c[14:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		crc_out = c;
	end
endmodule

/* File: tb/flash_model.sv */
// Behavioural flash array that answers the word fetches of the scan unit.
`timescale 1ns/1ps
module flash_model #(
	parameter int ADDR_W = 16
) (
	input  wire logic [ADDR_W-1:0]	flash_addr,
	input  wire logic		flash_rd,
	output logic [15:0]		flash_rdata
);
	logic [7:0]	mem [256];
	logic [15:0]	word;
	// The even byte is the high half, so bytes reach the scanner in order.
	assign word = {mem[{flash_addr[7:1], 1'h0}], mem[{flash_addr[7:1], 1'h1}]};
	// Outside a fetch the bus shows the inverted word, so a late sample fails.
	assign flash_rdata = flash_rd ? word : ~word;
endmodule

/* File: tb/scan_sva.sv */
// Port-level property checker of the memory scan unit.
`timescale 1ns/1ps
module scan_sva
	import scan_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic		clk,
	input wire logic		srst,
	input wire logic [1:0]		avs_address,
	input wire logic		avs_read,
	input wire logic		avs_write,
	input wire logic [31:0]		avs_writedata,
	input wire logic [31:0]		avs_readdata,
	input wire scan_pkg::debug_evt_s	dbg_evt,
	input wire logic [1:0]		dbg_status_copy,
	input wire logic [ADDR_W-1:0]	flash_addr,
	input wire logic		flash_rd,
	input wire logic		cpu_stall,
	input wire logic		failure_irq
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// Enable write; byte lane 0 is taken as active, as every master has it.
	logic	en_wr;
	assign en_wr = avs_write && avs_address == REG_CONTROL_IDX &&
		avs_writedata[CTL_ENABLE_BIT];
	// Each check ties an output to its cause; the cycle counts are checked only as lower bounds.
	chk_fetch_gap: assert property (flash_rd |=> !flash_rd [*2])
		else $error("flash words fetched closer than three cycles");
	chk_word_step: assert property ($past(flash_rd, 3) && flash_rd
		|-> flash_addr - $past(flash_addr, 3) == ADDR_W'(2))
		else $error("fetch address did not step by one word");
	chk_start_wait: assert property (en_wr && !cpu_stall &&
		!flash_rd && !dbg_status_copy[0] |=> !flash_rd [*3])
		else $error("scan fetched before its three wait cycles");
	chk_hold_quiet: assert property (dbg_evt.mem_access
		|=> !flash_rd [*2])
		else $error("fetch while the debugger holds the scanner");
	chk_hold_free: assert property (dbg_evt.mem_access |=> !cpu_stall)
		else $error("processor still stalled while scanner is held");
	chk_irq_sticky: assert property (failure_irq |=> failure_irq)
		else $error("failure interrupt dropped without system reset");
	chk_reset_state: assert property ($fell(srst) |-> !failure_irq &&
		dbg_status_copy == 2'h2 && !cpu_stall)
		else $error("wrong state right after reset");
	chk_unmapped_zero: assert property (avs_read &&
		avs_address == REG_DEBUG_IDX |=> avs_readdata == 32'h0)
		else $error("unmapped register read not zero");
	chk_status_bits: assert property (avs_read &&
		avs_address == REG_STATUS_IDX |=> avs_readdata[31:2] == 30'h0)
		else $error("unused status bits not zero");
	chk_mode_bits: assert property (avs_read &&
		avs_address == REG_SRCMODE_IDX |=>
		(avs_readdata & ~{24'h0, SRCMODE_MASK}) == 32'h0)
		else $error("unused source and mode bits not zero");
	cov_fetch: cover property (flash_rd);
	cov_irq: cover property ($rose(failure_irq));
	cov_hold: cover property (dbg_evt.mem_access && cpu_stall);
endmodule
bind memory_scan_unit scan_sva #(.ADDR_W(ADDR_W)) scan_sva_inst (
	.clk(clk), .srst(srst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.dbg_evt(dbg_evt), .dbg_status_copy(dbg_status_copy),
	.flash_addr(flash_addr), .flash_rd(flash_rd),
	.cpu_stall(cpu_stall), .failure_irq(failure_irq)
);

/* File: tb/tb_memory_scan_unit.sv */
// Self-checking bench of the memory scan unit with a flash model.
`timescale 1ns/1ps
module tb_memory_scan_unit;
	import scan_pkg::*;
	typedef struct {
		logic [1:0]	src;
		int		n;
		bit		bad;
		logic [31:0]	st;
	} row_s;
	logic		clk;
	logic		srst;
	logic [1:0]	avs_address;
	logic		avs_read;
	logic		avs_write;
	logic [31:0]	avs_writedata;
	logic [31:0]	avs_readdata;
	logic		avs_waitrequest;
	debug_evt_s	dbg_evt;
	logic		dbg_status_we;
	logic [1:0]	dbg_status_wdata;
	logic [1:0]	dbg_status_copy;
	logic		startup_scan;
	logic [1:0]	startup_region;
	logic [15:0]	flash_addr;
	logic		flash_rd;
	logic [15:0]	flash_rdata;
	logic		cpu_stall;
	logic		failure_irq;
	logic [31:0]	v;
	int		fails = 0;
	int		n_tests = 0;
	int		n_fetch = 0;
	int		f0;
	row_s		rows [5] = '{'{2'h0, 32, 1'h0, 32'h02},
		'{2'h1, 16, 1'h0, 32'h02}, '{2'h2, 8, 1'h0, 32'h02},
		'{2'h3, 32, 1'h0, 32'h02}, '{2'h1, 16, 1'h1, 32'h00}};
	// Sections end at bytes 8, 16 and 32 to keep each scan short.
	memory_scan_unit memory_scan_unit_inst (
		.clk(clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.dbg_evt(dbg_evt), .dbg_status_we(dbg_status_we),
		.dbg_status_wdata(dbg_status_wdata),
		.dbg_status_copy(dbg_status_copy), .startup_scan(startup_scan),
		.startup_region(startup_region), .flash_end(16'h0020),
		.boot_end(16'h0008), .app_end(16'h0010), .flash_addr(flash_addr),
		.flash_rd(flash_rd), .flash_rdata(flash_rdata),
		.cpu_stall(cpu_stall), .failure_irq(failure_irq)
	);
	flash_model flash_model_inst (
		.flash_addr(flash_addr), .flash_rd(flash_rd),
		.flash_rdata(flash_rdata)
	);
	// ****************
	// Clock, counters and tasks
	// ****************
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// Word fetches are counted to prove a scan ran, or did not.
	always @(posedge clk) begin
		if (flash_rd === 1'h1)
			n_fetch <= n_fetch + 1;
	end
	// A hang ends the run through the normal verdict.
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		give_verdict();
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= 1'h1;
		do @(posedge clk); while (avs_waitrequest !== 1'h0);
		avs_write <= 1'h0;
	endtask
	// Read data is taken at the edge where the wait state ends.
	task automatic reg_is(input logic [1:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'h1;
		do @(posedge clk); while (avs_waitrequest !== 1'h0);
		v = avs_readdata;
		avs_read <= 1'h0;
		if (m != 32'h0)
			check($sformatf("register %0d", a), v & m, exp);
	endtask
	task automatic poke(input logic [3:0] e, input logic we, input logic [1:0] d);
		@(posedge clk);
		dbg_evt <= debug_evt_s'(e);
		dbg_status_we <= we;
		dbg_status_wdata <= d;
		@(posedge clk);
		dbg_evt <= debug_evt_s'(4'h0);
		dbg_status_we <= 1'h0;
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			reg_is(REG_STATUS_IDX, 32'h0, 32'h0);
			k++;
		end while (v[ST_BUSY_BIT] !== 1'h0 && k < 100);
		if (k >= 100)
			fails++;
	endtask
	task automatic hold_start();
		wr(REG_CONTROL_IDX, 8'h01);
		repeat (6) @(posedge clk);
		poke(4'h8, 1'h0, 2'h0);
	endtask
	// Fills flash and stores the checksum of bytes 0 to n-3 behind them.
	task automatic prep(input int n, input bit bad);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = 0; i < 256; i++)
			flash_model_inst.mem[i] = 8'(i * 37 + 5);
		for (int i = 0; i < n - 2; i++) begin
			c ^= {flash_model_inst.mem[i], 8'h00};
			for (int b = 0; b < 8; b++)
				c = c[15] ? (c << 1) ^ CRC_POLY : c << 1;
		end
		flash_model_inst.mem[n - 2] = c[15:8];
		flash_model_inst.mem[n - 1] = c[7:0];
		if (bad)
			flash_model_inst.mem[1] = ~flash_model_inst.mem[1];
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		srst = 1'h1;
		{avs_address, avs_read, avs_write, avs_writedata} = 36'h0;
		{dbg_evt, dbg_status_we, dbg_status_wdata} = 7'h0;
		{startup_scan, startup_region} = 3'h0;
		repeat (20) @(posedge clk);
		srst <= 1'h0;
		reg_is(REG_CONTROL_IDX, 32'h00);
		reg_is(REG_SRCMODE_IDX, 32'h00);
		reg_is(REG_STATUS_IDX, 32'h02);
		reg_is(REG_DEBUG_IDX, 32'h00);
		check("copy", dbg_status_copy, 32'h2);
		foreach (rows[i]) begin
			prep(rows[i].n, rows[i].bad);
			f0 = n_fetch;
			wr(REG_SRCMODE_IDX, {6'h0, rows[i].src});
			wr(REG_CONTROL_IDX, 8'h01);
			reg_is(REG_STATUS_IDX, 32'h1, 32'h1);
			check("stall", cpu_stall, 32'h1);
			wait_idle();
			reg_is(REG_STATUS_IDX, rows[i].st);
			reg_is(REG_CONTROL_IDX, 32'h01);
			check("fetches", n_fetch - f0, rows[i].n / 2);
		end
		poke(4'h0, 1'h1, 2'h2);
		reg_is(REG_STATUS_IDX, 32'h02);
		prep(32, 1'h0);
		wr(REG_SRCMODE_IDX, 8'h00);
		hold_start();
		repeat (20) @(posedge clk);
		check("stall", cpu_stall, 32'h0);
		reg_is(REG_STATUS_IDX, 32'h1, 32'h1);
		f0 = n_fetch;
		poke(4'h4, 1'h0, 2'h0);
		wait_idle();
		check("restart", n_fetch - f0, 32'd16);
		hold_start();
		poke(4'h1, 1'h0, 2'h0);
		wait_idle();
		reg_is(REG_STATUS_IDX, 32'h02);
		hold_start();
		poke(4'h0, 1'h1, 2'h2);
		f0 = n_fetch;
		poke(4'h2, 1'h0, 2'h0);
		repeat (30) @(posedge clk);
		check("abort", n_fetch - f0, 32'h0);
		poke(4'h8, 1'h0, 2'h0);
		poke(4'h0, 1'h1, 2'h3);
		repeat (10) @(posedge clk);
		check("pending", n_fetch - f0, 32'h0);
		poke(4'h2, 1'h0, 2'h0);
		wait_idle();
		check("single", n_fetch - f0, 32'd16);
		wr(REG_CONTROL_IDX, 8'h01);
		wr(REG_SRCMODE_IDX, 8'h32);
		wr(REG_CONTROL_IDX, 8'h02);
		reg_is(REG_SRCMODE_IDX, 32'h00);
		reg_is(REG_CONTROL_IDX, 32'h01);
		wr(REG_CONTROL_IDX, 8'h80);
		reg_is(REG_CONTROL_IDX, 32'h00);
		reg_is(REG_STATUS_IDX, 32'h0, 32'h1);
		wr(REG_CONTROL_IDX, 8'h03);
		wr(REG_CONTROL_IDX, 8'h80);
		reg_is(REG_CONTROL_IDX, 32'h03);
		wait_idle();
		wr(REG_CONTROL_IDX, 8'h80);
		reg_is(REG_CONTROL_IDX, 32'h02);
		poke(4'h0, 1'h1, 2'h0);
		repeat (2) @(posedge clk);
		check("irq", failure_irq, 32'h1);
		wr(REG_SRCMODE_IDX, 8'h01);
		reg_is(REG_SRCMODE_IDX, 32'h00);
		f0 = n_fetch;
		wr(REG_CONTROL_IDX, 8'h01);
		repeat (10) @(posedge clk);
		check("locked", n_fetch - f0, 32'h0);
		srst <= 1'h1;
		startup_scan <= 1'h1;
		startup_region <= REGION_BOOT;
		prep(8, 1'h0);
		repeat (20) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		check("irq", failure_irq, 32'h0);
		wait_idle();
		reg_is(REG_CONTROL_IDX, 32'h01);
		reg_is(REG_SRCMODE_IDX, 32'h02, 32'h03);
		check("mode", v[5:4] != 2'h0, 32'h1);
		wr(REG_SRCMODE_IDX, 8'h00);
		reg_is(REG_SRCMODE_IDX, 32'h00);
		give_verdict();
	end
endmodule
